// ==== hdl/irq_delay_timer.sv ====
// Qualification timer: fires one pulse once its level input has stayed
// high for COUNT consecutive clocks; assumes a synchronous, clean level.
`timescale 1ns/100ps
`default_nettype none

module irq_delay_timer #(
  parameter int COUNT = 16,
  parameter int W = $clog2(COUNT + 1)
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic level, // Level to qualify.
  output logic fire // One-cycle pulse after COUNT high cycles.
);
  logic [W-1:0] count;
  logic done;

  // A drop of the level restarts the wait, so chatter near the
  // threshold never shortens the delay.
  always_ff @(posedge clk) begin
    if (rst || !level) begin
      count <= '0;
      done <= 1'b0;
      fire <= 1'b0;
    end else if (!done) begin
      fire <= (count == W'(COUNT - 1));
      done <= (count == W'(COUNT - 1));
      count <= count + W'(1);
    end else begin
      fire <= 1'b0;
    end
  end
endmodule // irq_delay_timer

`default_nettype wire

// ==== hdl/supply_monitor_irq_wakeup.sv ====
// Supply monitor control, interrupt flags, wake-up and return-address stack.
// Assumes an AXI4-Lite master, an analogue comparator and a core that
// acknowledges vectors and reports its return instructions as pulses.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module supply_monitor_irq_wakeup (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [3:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [3:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic lvd_compare_in, // Raw comparator, high when supply low.
  output logic detector_power_on, // Powers the detector circuits.
  output logic reference_enable, // Powers the detector reference.
  output logic bandgap_buffer_on, // Bandgap buffer enable.
  output logic [2:0] threshold_code, // Selected threshold, 2.0V..4.0V.
  input wire logic [1:0] member_event, // Member source events of group.
  input wire logic sleep_mode, // Core is in sleep mode.
  input wire logic idle_mode, // Core is in idle mode.
  output logic wake_pulse, // One-cycle wake request.
  output logic irq_request, // Vector request to the core.
  output supply_monitor_pkg::irq_vector_t irq_vector, // Requested vector.
  input wire logic service_ack, // Core takes the vector.
  input wire logic [11:0] return_pc, // Program counter to push.
  input wire logic ret_pulse, // Plain return executed.
  input wire logic return_reenable_instr_pulse, // Re-enabling return executed.
  output logic [11:0] resume_pc // Popped program counter.
);
  logic [7:0] control;
  logic [supply_monitor_pkg::IE_W-1:0] irq_enable;
  logic [supply_monitor_pkg::FLAGS_W-1:0] flags;
  logic [supply_monitor_pkg::FLAGS_W-1:0] next_flags;
  logic [supply_monitor_pkg::FLAGS_W-1:0] svc_clear;
  logic [supply_monitor_pkg::FLAGS_W-1:0] hw_set;
  logic cmp_meta, cmp_sync, low_voltage_flag, lv_fire;
  logic aw_held, w_held;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire, wr_ctrl, wr_ie, wr_flags;
  logic [31:0] read_value;
  logic read_ok;
  logic [supply_monitor_pkg::PC_W-1:0] stack_mem [supply_monitor_pkg::STACK_DEPTH];
  logic [supply_monitor_pkg::DEPTH_W-1:0] depth;
  logic stack_full, pending_lv, pending_grp, pop;
  logic [10:0] flag_run;

  // Write channel: address and data are latched independently.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl = wr_fire && wr_strb[0] && wr_addr == supply_monitor_pkg::CTRL_OFFSET;
  assign wr_ie = wr_fire && wr_strb[0] && wr_addr == supply_monitor_pkg::IRQ_ENABLE_OFFSET;
  assign wr_flags = wr_fire && wr_strb[0] && wr_addr == supply_monitor_pkg::IRQ_FLAG_OFFSET;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr == supply_monitor_pkg::STACK_STATUS_OFFSET) ?
                       supply_monitor_pkg::RESP_SLVERR : supply_monitor_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one word per address, answered one cycle later.
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    read_value = 32'h0;
    read_ok = 1'b1;
    unique case ({s_axi_araddr[3:2], 2'h0})
      supply_monitor_pkg::CTRL_OFFSET: read_value[7:0] = control;
      supply_monitor_pkg::IRQ_ENABLE_OFFSET: read_value[2:0] = irq_enable;
      supply_monitor_pkg::IRQ_FLAG_OFFSET: read_value[3:0] = flags;
      supply_monitor_pkg::STACK_STATUS_OFFSET: read_value[3:0] = {stack_full, depth};
      default: read_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_value;
      s_axi_rresp <= read_ok ? supply_monitor_pkg::RESP_OKAY : supply_monitor_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= lvd_compare_in;
      cmp_sync <= cmp_meta;
    end
  end

  assign detector_power_on = control[supply_monitor_pkg::DET_EN_BIT] && !sleep_mode;
  assign reference_enable = detector_power_on;
  assign bandgap_buffer_on = control[supply_monitor_pkg::BANDGAP_BIT];
  assign threshold_code = control[supply_monitor_pkg::THR_W-1:0];
  assign low_voltage_flag = cmp_sync && detector_power_on;

  // Read-only flag bit; writable bits, reserved zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      control <= supply_monitor_pkg::CTRL_RESET;
    end else begin
      control[supply_monitor_pkg::FLAG_BIT] <= low_voltage_flag;
      if (wr_ctrl) begin
        control[4:0] <= wr_data[4:0] & supply_monitor_pkg::CTRL_WRITE_MASK[4:0];
      end
    end
  end

  irq_delay_timer #(
    .COUNT(supply_monitor_pkg::IRQ_DELAY_CYCLES)
  ) u_irq_delay (
    .clk(clk),
    .rst(rst),
    .level(low_voltage_flag),
    .fire(lv_fire)
  );

  // Length of the current run of the flag, so the delay check sees the whole wait.
  always_ff @(posedge clk) begin
    if (rst || !low_voltage_flag) begin
      flag_run <= 11'h000;
    end else if (flag_run != 11'h7ff) begin
      flag_run <= flag_run + 11'h001;
    end
  end

  assign pending_lv = flags[supply_monitor_pkg::LV_FLAG_BIT] &&
                      irq_enable[supply_monitor_pkg::LV_IE_BIT];
  assign pending_grp = flags[supply_monitor_pkg::GRP_FLAG_BIT] &&
                       irq_enable[supply_monitor_pkg::GRP_IE_BIT];
  assign stack_full = depth == supply_monitor_pkg::DEPTH_W'(supply_monitor_pkg::STACK_DEPTH);
  assign irq_request = irq_enable[supply_monitor_pkg::GIE_BIT] && !stack_full &&
                       (pending_lv || pending_grp);
  assign irq_vector = pending_lv ? supply_monitor_pkg::VEC_LOW_VOLTAGE :
                      supply_monitor_pkg::VEC_GROUPED;

  // Grouped service clears only grouped flag.
  always_comb begin
    svc_clear = '0;
    hw_set = '0;
    if (service_ack && irq_request) begin
      if (irq_vector == supply_monitor_pkg::VEC_LOW_VOLTAGE) begin
        svc_clear[supply_monitor_pkg::LV_FLAG_BIT] = 1'b1;
      end else begin
        svc_clear[supply_monitor_pkg::GRP_FLAG_BIT] = 1'b1;
      end
    end
    hw_set[supply_monitor_pkg::LV_FLAG_BIT] = lv_fire;
    hw_set[supply_monitor_pkg::GRP_FLAG_BIT] = |member_event;
    hw_set[supply_monitor_pkg::MEMBER_LSB +: supply_monitor_pkg::MEMBER_N] = member_event;
  end

  // Sticky flags, hardware set wins over any clear.
  assign next_flags = (((wr_flags ? wr_data[3:0] : flags) & ~svc_clear) | hw_set);

  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= '0;
      wake_pulse <= 1'b0;
    end else begin
      flags <= next_flags;
      wake_pulse <= (sleep_mode || idle_mode) && |(next_flags & ~flags);
    end
  end

  // Service clears enable; re-enabling return sets it.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable <= '0;
    end else begin
      if (wr_ie) begin
        irq_enable <= wr_data[supply_monitor_pkg::IE_W-1:0];
      end
      if (service_ack && irq_request) begin
        irq_enable[supply_monitor_pkg::GIE_BIT] <= 1'b0;
      end else if (return_reenable_instr_pulse && depth != '0) begin
        irq_enable[supply_monitor_pkg::GIE_BIT] <= 1'b1;
      end
    end
  end

  // Push only the program counter; plain return only pops.
  assign pop = (ret_pulse || return_reenable_instr_pulse) && depth != '0 && !(service_ack && irq_request);

  always_ff @(posedge clk) begin
    if (rst) begin
      depth <= '0;
      resume_pc <= 12'h000;
    end else if (service_ack && irq_request) begin
      stack_mem[depth[1:0]] <= return_pc;
      depth <= depth + supply_monitor_pkg::DEPTH_W'(1);
    end else if (pop) begin
      resume_pc <= stack_mem[2'(depth - supply_monitor_pkg::DEPTH_W'(1))];
      depth <= depth - supply_monitor_pkg::DEPTH_W'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_wake_on_rise: assert property (
    $rose(flags[0]) && $past(sleep_mode) |-> wake_pulse)
    else $error("no wake on rising flag");
  chk_flag_sticky: assert property (
    flags[0] && !wr_flags && !(service_ack && irq_request) |=> flags[0])
    else $error("request flag lost");
  chk_masked_quiet: assert property (
    !irq_enable[1] && !irq_enable[2] |-> !irq_request)
    else $error("disabled interrupt requested");
  chk_group_clear: assert property (
    service_ack && irq_request && irq_vector == supply_monitor_pkg::VEC_GROUPED &&
    member_event == 2'h0 && !wr_flags |=> !flags[1] && flags[3:2] == $past(flags[3:2]))
    else $error("grouped service cleared wrong flags");
  chk_push_depth: assert property (
    service_ack && irq_request |=> depth == $past(depth) + 3'h1)
    else $error("stack push missing");
  chk_return_reenable_instr_enable: assert property (
    return_reenable_instr_pulse && depth != 3'h0 && !service_ack |=> irq_enable[0] && depth == $past(depth) - 3'h1)
    else $error("re-enabling return failed");
  chk_ret_plain: assert property (
    ret_pulse && !irq_enable[0] && !wr_ie |=> !irq_enable[0])
    else $error("plain return set enable");
  chk_reserved_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && control[7:6] == 2'h0)
    else $error("reserved bits not zero");
  chk_sleep_off: assert property (
    sleep_mode |-> !detector_power_on && !low_voltage_flag)
    else $error("detector on during sleep");
  chk_ref_auto: assert property (
    control[supply_monitor_pkg::DET_EN_BIT] && !sleep_mode |-> reference_enable)
    else $error("reference not enabled");
  chk_flag_synced: assert property (
    low_voltage_flag |-> $past(lvd_compare_in, 2))
    else $error("flag not from synchronised input");
  chk_irq_delayed: assert property (
    lv_fire |-> flag_run >= 11'(supply_monitor_pkg::IRQ_DELAY_CYCLES))
    else $error("low-voltage request too early");
  chk_service_gie: assert property (
    service_ack && irq_request |=> !irq_enable[0])
    else $error("enable not cleared on service");

  cov_wake: cover property (sleep_mode ##1 wake_pulse);
  cov_lv_service: cover property (lv_fire ##[1:20] (service_ack && irq_request));
  cov_return_reenable_instr: cover property ((service_ack && irq_request) ##[1:20] return_reenable_instr_pulse);
endmodule // supply_monitor_irq_wakeup

`default_nettype wire

// ==== include/supply_monitor_pkg.sv ====
// Constants, register map and types shared by the supply monitor design.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
//
// What this block does
// - Rising request flag wakes from sleep/idle.
// - Request flags stay set until serviced/cleared.
// - Disabled interrupt is never serviced.
// - Servicing grouped clears only grouped flag.
// - Entry pushes only program counter.
// - Re-enabling return restores PC, sets enable.
// - Plain return restores PC only.
// - Control bit 5 is read-only low-voltage flag.
// - Control bit 4 enables the detector.
// - Control bit 3 enables bandgap buffer.
// - Control bits 2:0 select eight thresholds.
// - Bits 7:6 read zero; reset clears all.
// - Flag follows detector, may toggle near threshold.
// - Reference enabled automatically while detector runs.
// - Sleep forces the detector off.
// - Low-voltage request raised after fixed delay.
// - Servicing clears the global interrupt enable.

`default_nettype none

package supply_monitor_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] IRQ_ENABLE_OFFSET = 4'h4;
  localparam logic [3:0] IRQ_FLAG_OFFSET = 4'h8;
  localparam logic [3:0] STACK_STATUS_OFFSET = 4'hc;

  localparam int FLAG_BIT = 5;
  localparam int DET_EN_BIT = 4;
  localparam int BANDGAP_BIT = 3;
  localparam int THR_W = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h1f;

  localparam int GIE_BIT = 0;
  localparam int LV_IE_BIT = 1;
  localparam int GRP_IE_BIT = 2;
  localparam int IE_W = 3;

  localparam int LV_FLAG_BIT = 0;
  localparam int GRP_FLAG_BIT = 1;
  localparam int MEMBER_LSB = 2;
  localparam int MEMBER_N = 2;
  localparam int FLAGS_W = 4;

  localparam int CLK_MHZ = 100;
  localparam int IRQ_DELAY_NS = 15000;
  localparam int IRQ_DELAY_CYCLES = (IRQ_DELAY_NS * CLK_MHZ + 999) / 1000;

  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 4;
  localparam int DEPTH_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    VEC_LOW_VOLTAGE = 1'b0,
    VEC_GROUPED = 1'b1
  } irq_vector_t;
endpackage

`default_nettype wire

// ==== verification/tb_supply_monitor_irq_wakeup.sv ====
// Self-checking bench for the supply monitor: register map, wake-up and return stack.
// Assumes the design's AXI4-Lite slave, a 100 MHz clock and no partner model.
`timescale 1ns/100ps
`default_nettype none

module tb_supply_monitor_irq_wakeup;
  localparam logic [3:0] CTRL = supply_monitor_pkg::CTRL_OFFSET;
  localparam logic [3:0] IEN = supply_monitor_pkg::IRQ_ENABLE_OFFSET;
  localparam logic [3:0] FLG = supply_monitor_pkg::IRQ_FLAG_OFFSET;
  localparam logic [3:0] STAT = supply_monitor_pkg::STACK_STATUS_OFFSET;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic cmp = 1'b0, sleep = 1'b0, idle = 1'b0, ack = 1'b0, ret = 1'b0, return_reenable_instr = 1'b0;
  logic [1:0] mev = 2'h0;
  logic [11:0] rpc = 12'h0;
  logic [11:0] resume_pc;
  logic det_on, ref_en, bg_on, wake, irq, seen;
  logic [2:0] thr;
  supply_monitor_pkg::irq_vector_t vec;
  int err_count = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  supply_monitor_irq_wakeup i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .lvd_compare_in(cmp), .detector_power_on(det_on),
    .reference_enable(ref_en), .bandgap_buffer_on(bg_on), .threshold_code(thr),
    .member_event(mev), .sleep_mode(sleep), .idle_mode(idle), .wake_pulse(wake),
    .irq_request(irq), .irq_vector(vec), .service_ack(ack), .return_pc(rpc),
    .ret_pulse(ret), .return_reenable_instr_pulse(return_reenable_instr), .resume_pc(resume_pc));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Both channels are offered together; bready stays up until the answer.
  task axi_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    chk(nm, e, rdata);
    chk("rresp", 32'h0, 32'(rresp));
    rready <= 1'b0;
  endtask

  // One-cycle core strobe: 0 service_ack, 1 plain return, 2 re-enabling return.
  task pulse(input int sel);
    @(posedge clk);
    ack <= (sel == 0);
    ret <= (sel == 1);
    return_reenable_instr <= (sel == 2);
    @(posedge clk);
    ack <= 1'b0;
    ret <= 1'b0;
    return_reenable_instr <= 1'b0;
    #1;
  endtask

  task test_reset;
    rd_chk("ctrl", CTRL, 32'h0);
    rd_chk("ien", IEN, 32'h0);
    rd_chk("flags", FLG, 32'h0);
    axi_write(STAT, 32'hf);
    chk("stat resp", 32'(supply_monitor_pkg::RESP_SLVERR), 32'(resp));
    $display("test_reset done");
  endtask

  task test_ctrl;
    for (int i = 0; i < 8; i++) begin
      axi_write(CTRL, 32'hf8 | i);
      rd_chk("ctrl rw", CTRL, 32'h18 | i);
      chk("thr", 32'(i), 32'(thr));
      chk("bandgap", 32'h1, 32'(bg_on));
      chk("det on", 32'h1, 32'(det_on));
      chk("ref en", 32'h1, 32'(ref_en));
    end
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    #1;
    chk("det sleep", 32'h0, 32'(det_on));
    chk("ref sleep", 32'h0, 32'(ref_en));
    @(posedge clk);
    sleep <= 1'b0;
    $display("test_ctrl done");
  endtask

  // The request flag may only rise once the flag held for the full delay.
  task test_detector;
    @(posedge clk);
    cmp <= 1'b1;
    repeat (supply_monitor_pkg::IRQ_DELAY_CYCLES - 50) @(posedge clk);
    rd_chk("flag high", CTRL, 32'h3f);
    rd_chk("lv early", FLG, 32'h0);
    repeat (80) @(posedge clk);
    rd_chk("lv late", FLG, 32'h1);
    chk("irq masked", 32'h0, 32'(irq));
    cmp <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk("flag low", CTRL, 32'h1f);
    rd_chk("lv kept", FLG, 32'h1);
    $display("test_detector done");
  endtask

  task test_wake;
    for (int m = 0; m < 2; m++) begin
      axi_write(FLG, 32'h0);
      sleep <= (m == 0);
      idle <= (m == 1);
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        mev <= 2'h2;
        @(posedge clk);
        mev <= 2'h0;
        seen = 1'b0;
        repeat (4) begin
          #1;
          seen = seen | wake;
          @(posedge clk);
        end
        chk("wake", 32'(k == 0), 32'(seen));
      end
    end
    sleep <= 1'b0;
    idle <= 1'b0;
    $display("test_wake done");
  endtask

  task test_service;
    axi_write(FLG, 32'he);
    axi_write(IEN, 32'h1);
    chk("irq off", 32'h0, 32'(irq));
    axi_write(IEN, 32'h5);
    chk("irq on", 32'h1, 32'(irq));
    chk("vector", 32'(supply_monitor_pkg::VEC_GROUPED), 32'(vec));
    rpc <= 12'h123;
    pulse(0);
    rd_chk("group clr", FLG, 32'hc);
    rd_chk("depth", STAT, 32'h1);
    rd_chk("gie clr", IEN, 32'h4);
    pulse(2);
    chk("return_reenable_instr pc", 32'h123, 32'(resume_pc));
    rd_chk("gie set", IEN, 32'h5);
    axi_write(FLG, 32'he);
    rpc <= 12'h2ab;
    pulse(0);
    pulse(1);
    chk("ret pc", 32'h2ab, 32'(resume_pc));
    rd_chk("gie held", IEN, 32'h4);
    axi_write(FLG, 32'h3);
    axi_write(IEN, 32'h7);
    chk("vector lv", 32'(supply_monitor_pkg::VEC_LOW_VOLTAGE), 32'(vec));
    pulse(0);
    rd_chk("lv clr", FLG, 32'h2);
    pulse(2);
    rd_chk("depth 0", STAT, 32'h0);
    $display("test_service done");
  endtask

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_ctrl();
    test_detector();
    test_wake();
    test_service();
    give_verdict();
  end
endmodule // tb_supply_monitor_irq_wakeup

`default_nettype wire
